// ---- rtl/adchp_pkg.sv ----
// Purpose: constants for the record-path high-pass coefficient bank
// Assumes: page 1 register space, 8-bit registers, 7-bit register address
// Notes:   byte index 0 of the bank sits at the coefficient base offset
package adchp_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int COEF_W = 16;
  localparam int NUM_BYTES = 8;
  localparam int NUM_COEFS = 4;
  localparam int BYTE_IDX_W = 3;
  localparam int COEF_IDX_W = 2;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [6:0] LEFT_HPF_FEEDBACK_COEF_HIGH_OFS = 7'h45;
  localparam logic [6:0] LEFT_HPF_FEEDBACK_COEF_LOW_OFS = 7'h46;
  localparam logic [6:0] RIGHT_HPF_NUM0_COEF_HIGH_OFS = 7'h47;
  localparam logic [6:0] RIGHT_HPF_NUM0_COEF_LOW_OFS = 7'h48;
  localparam logic [6:0] RIGHT_HPF_NUM1_COEF_HIGH_OFS = 7'h49;
  localparam logic [6:0] RIGHT_HPF_NUM1_COEF_LOW_OFS = 7'h4a;
  localparam logic [6:0] RIGHT_HPF_FEEDBACK_COEF_HIGH_OFS = 7'h4b;
  localparam logic [6:0] RIGHT_HPF_FEEDBACK_COEF_LOW_OFS = 7'h4c;
  localparam logic [6:0] RESERVED_TAIL_FIRST_OFS = 7'h4d;
  localparam logic [6:0] RESERVED_TAIL_LAST_OFS = 7'h7f;
  localparam logic [6:0] COEF_BASE_OFS = LEFT_HPF_FEEDBACK_COEF_HIGH_OFS;

  // ----------------------------------------------------------------
  // coefficient slots: high byte at 2*slot, low byte at 2*slot+1
  // ----------------------------------------------------------------
  localparam logic [1:0] SLOT_LEFT_FEEDBACK = 2'h0;
  localparam logic [1:0] SLOT_RIGHT_FIRST_NUM = 2'h1;
  localparam logic [1:0] SLOT_RIGHT_SECOND_NUM = 2'h2;
  localparam logic [1:0] SLOT_RIGHT_FEEDBACK = 2'h3;

  // ----------------------------------------------------------------
  // reset values, index 7 leftmost
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_LEFT_FB_HIGH = 8'h53;
  localparam logic [7:0] RST_LEFT_FB_LOW = 8'h7e;
  localparam logic [7:0] RST_RIGHT_NUM0_HIGH = 8'h39;
  localparam logic [7:0] RST_RIGHT_NUM0_LOW = 8'h55;
  localparam logic [7:0] RST_RIGHT_NUM1_HIGH = 8'hf3;
  localparam logic [7:0] RST_RIGHT_NUM1_LOW = 8'h2d;
  localparam logic [7:0] RST_RIGHT_FB_HIGH = 8'h53;
  localparam logic [7:0] RST_RIGHT_FB_LOW = 8'h7e;
  localparam logic [7:0] RESERVED_READ_VAL = 8'h00;
  localparam logic [NUM_BYTES-1:0][DATA_W-1:0] COEF_RST = {
    RST_RIGHT_FB_LOW, RST_RIGHT_FB_HIGH,
    RST_RIGHT_NUM1_LOW, RST_RIGHT_NUM1_HIGH,
    RST_RIGHT_NUM0_LOW, RST_RIGHT_NUM0_HIGH,
    RST_LEFT_FB_LOW, RST_LEFT_FB_HIGH
  };

endpackage

// ---- rtl/adchp_coef_mem.sv ----
// Purpose: byte store for the coefficient bank with registered read data
// Assumes: write and read never requested in the same cycle
// Notes:   read data is zero when no read is requested
`timescale 1ns/1ps

module adchp_coef_mem #(
  parameter int DEPTH = adchp_pkg::NUM_BYTES,
  parameter int WIDTH = adchp_pkg::DATA_W,
  parameter logic [DEPTH-1:0][WIDTH-1:0] RST_VAL = adchp_pkg::COEF_RST
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic wr_en_in,
  input wire logic [$clog2(DEPTH)-1:0] wr_idx_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic rd_en_in,
  input wire logic [$clog2(DEPTH)-1:0] rd_idx_in,
  output logic [WIDTH-1:0] rd_data_out,
  output logic [DEPTH-1:0][WIDTH-1:0] words_out
);
  import adchp_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0] rdata;
  } adchp_mem_state_t;

  adchp_mem_state_t state_reg;
  adchp_mem_state_t state_next;

  if (DEPTH < 2) begin : g_depth_check
    $error("adchp_coef_mem: DEPTH must be at least 2");
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.rdata = '0;
    if (wr_en_in) begin
      state_next.mem[wr_idx_in] = wr_data_in;
    end
    if (rd_en_in) begin
      state_next.rdata = state_reg.mem[rd_idx_in];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      state_reg.mem <= RST_VAL;
      state_reg.rdata <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rd_data_out = state_reg.rdata;
  assign words_out = state_reg.mem;

endmodule // adchp_coef_mem

// ---- rtl/adchp_coef_regs.sv ----
// Purpose: page 1 high-pass coefficient registers for the record path
// Assumes: page selection is decoded outside; address is page-local
// Notes:   coefficient outputs feed the filter datapath as signed words
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps

// Overview of operation
// - register 0x46 holds left feedback coefficient low byte, resets to 0x7e
// - register 0x45 holds left feedback coefficient high byte, resets 0x53
// - registers 0x47/0x48 hold right first numerator, reset 0x39/0x55
// - registers 0x49/0x4a hold right second numerator, reset 0xf3/0x2d
// - registers 0x4b/0x4c hold right feedback coefficient, reset 0x53/0x7e
// - high and low bytes join into one signed 16-bit coefficient
// - registers 0x4d to 0x7f read zero; host must not write them
module adchp_coef_regs #(
  parameter int ADDR_W = adchp_pkg::ADDR_W
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [adchp_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [adchp_pkg::DATA_W-1:0] reg_rdata_out,
  output logic signed [adchp_pkg::COEF_W-1:0] left_feedback_coef_out,
  output logic signed [adchp_pkg::COEF_W-1:0] right_first_numerator_coef_out,
  output logic signed [adchp_pkg::COEF_W-1:0] right_second_numerator_coef_out,
  output logic signed [adchp_pkg::COEF_W-1:0] right_feedback_coef_out,
  output logic [adchp_pkg::NUM_COEFS-1:0] coef_update_out,
  output logic rsvd_wr_seen_out
);
  import adchp_pkg::*;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (ADDR_W < adchp_pkg::ADDR_W) begin : g_addr_check
    $error("adchp_coef_regs: ADDR_W too narrow for page 1");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rsvd_wr_seen;
    logic [NUM_COEFS-1:0] coef_update;
  } adchp_regs_state_t;

  adchp_regs_state_t state_reg;
  adchp_regs_state_t state_next;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic is_coef_addr(input logic [ADDR_W-1:0] addr);
    return (addr >= ADDR_W'(COEF_BASE_OFS)) &&
           (addr <= ADDR_W'(RIGHT_HPF_FEEDBACK_COEF_LOW_OFS));
  endfunction

  function automatic logic is_rsvd_addr(input logic [ADDR_W-1:0] addr);
    return (addr >= ADDR_W'(RESERVED_TAIL_FIRST_OFS)) &&
           (addr <= ADDR_W'(RESERVED_TAIL_LAST_OFS));
  endfunction

  function automatic logic [BYTE_IDX_W-1:0] byte_idx(
    input logic [ADDR_W-1:0] addr
  );
    logic [ADDR_W-1:0] diff;
    diff = addr - ADDR_W'(COEF_BASE_OFS);
    return diff[BYTE_IDX_W-1:0];
  endfunction

  logic wr_coef;
  logic wr_rsvd;
  logic rd_coef;
  logic [BYTE_IDX_W-1:0] wr_idx;
  logic [BYTE_IDX_W-1:0] rd_idx;

  // writes to the reserved tail are dropped, reads of it answer zero
  assign wr_coef = reg_wr_in && is_coef_addr(reg_addr_in);
  assign wr_rsvd = reg_wr_in && is_rsvd_addr(reg_addr_in);
  assign rd_coef = reg_rd_in && is_coef_addr(reg_addr_in);
  assign wr_idx = byte_idx(reg_addr_in);
  assign rd_idx = byte_idx(reg_addr_in);

  // ----------------------------------------------------------------
  // coefficient byte store
  // ----------------------------------------------------------------
  logic [NUM_BYTES-1:0][DATA_W-1:0] coef_bytes;
  logic [DATA_W-1:0] mem_rdata;

  // reset values of every byte come from the bank table
  adchp_coef_mem #(
    .DEPTH(NUM_BYTES),
    .WIDTH(DATA_W),
    .RST_VAL(COEF_RST)
  ) u_coef_mem (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .wr_en_in(wr_coef),
    .wr_idx_in(wr_idx),
    .wr_data_in(reg_wdata_in),
    .rd_en_in(rd_coef),
    .rd_idx_in(rd_idx),
    .rd_data_out(mem_rdata),
    .words_out(coef_bytes)
  );

  // unmapped and reserved reads leave the store answer at zero
  assign reg_rdata_out = mem_rdata;

  // ----------------------------------------------------------------
  // signed coefficient words
  // ----------------------------------------------------------------
  logic [NUM_COEFS-1:0][COEF_W-1:0] coef_words;

  for (genvar c = 0; c < NUM_COEFS; c++) begin : g_coef
    assign coef_words[c] = {coef_bytes[2*c], coef_bytes[2*c+1]};
  end

  assign left_feedback_coef_out = signed'(coef_words[SLOT_LEFT_FEEDBACK]);
  assign right_first_numerator_coef_out =
    signed'(coef_words[SLOT_RIGHT_FIRST_NUM]);
  assign right_second_numerator_coef_out =
    signed'(coef_words[SLOT_RIGHT_SECOND_NUM]);
  assign right_feedback_coef_out = signed'(coef_words[SLOT_RIGHT_FEEDBACK]);

  // ----------------------------------------------------------------
  // update strobes and reserved-write flag
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.coef_update = '0;
    if (wr_coef) begin
      state_next.coef_update[wr_idx[BYTE_IDX_W-1:1]] = 1'b1;
    end
    if (wr_rsvd) begin
      state_next.rsvd_wr_seen = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign coef_update_out = state_reg.coef_update;
  assign rsvd_wr_seen_out = state_reg.rsvd_wr_seen;

  // ----------------------------------------------------------------
  // reset value checks
  // ----------------------------------------------------------------
  a_left_low_reset: assert property (
    @(posedge ref_clk_in)
    !rst_n_in |=> left_feedback_coef_out[7:0] == RST_LEFT_FB_LOW
  ) else $error("left feedback low byte wrong after reset");

  a_left_high_reset: assert property (
    @(posedge ref_clk_in)
    !rst_n_in |=> left_feedback_coef_out[15:8] == RST_LEFT_FB_HIGH
  ) else $error("left feedback high byte wrong after reset");

  a_right_num0_reset: assert property (
    @(posedge ref_clk_in)
    !rst_n_in |=> right_first_numerator_coef_out ==
      signed'({RST_RIGHT_NUM0_HIGH, RST_RIGHT_NUM0_LOW})
  ) else $error("right first numerator wrong after reset");

  a_right_num1_reset: assert property (
    @(posedge ref_clk_in)
    !rst_n_in |=> right_second_numerator_coef_out ==
      signed'({RST_RIGHT_NUM1_HIGH, RST_RIGHT_NUM1_LOW})
  ) else $error("right second numerator wrong after reset");

  a_right_fb_reset: assert property (
    @(posedge ref_clk_in)
    !rst_n_in |=> right_feedback_coef_out ==
      signed'({RST_RIGHT_FB_HIGH, RST_RIGHT_FB_LOW})
  ) else $error("right feedback coefficient wrong after reset");

  a_reset_readback: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    $past(!rst_n_in) && reg_rd_in &&
      reg_addr_in == ADDR_W'(LEFT_HPF_FEEDBACK_COEF_LOW_OFS)
    |=> reg_rdata_out == RST_LEFT_FB_LOW
  ) else $error("left feedback low byte reads wrong after reset");

  a_flag_reset: assert property (
    @(posedge ref_clk_in)
    !rst_n_in |=> !rsvd_wr_seen_out
  ) else $error("reserved write flag not cleared by reset");

  a_update_reset: assert property (
    @(posedge ref_clk_in)
    !rst_n_in |=> coef_update_out == 4'h0
  ) else $error("update strobes not cleared by reset");

  a_rdata_reset: assert property (
    @(posedge ref_clk_in)
    !rst_n_in |=> reg_rdata_out == 8'h00
  ) else $error("read data not cleared by reset");

  // ----------------------------------------------------------------
  // coefficient word checks
  // ----------------------------------------------------------------
  a_high_byte_lands: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    reg_wr_in && reg_addr_in == ADDR_W'(RIGHT_HPF_FEEDBACK_COEF_HIGH_OFS)
    |=> right_feedback_coef_out[15:8] == $past(reg_wdata_in) &&
        right_feedback_coef_out[7:0] == $past(right_feedback_coef_out[7:0])
  ) else $error("high byte write did not land in the upper half");

  a_sign_from_high: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    reg_wr_in && reg_addr_in == ADDR_W'(RIGHT_HPF_NUM1_COEF_HIGH_OFS) &&
      reg_wdata_in[7]
    |=> right_second_numerator_coef_out < 0
  ) else $error("negative high byte did not give a negative word");

  a_update_strobe: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    reg_wr_in && reg_addr_in == ADDR_W'(LEFT_HPF_FEEDBACK_COEF_LOW_OFS)
    |=> coef_update_out == 4'h1 ##1 coef_update_out == 4'h0 || $past(wr_coef)
  ) else $error("update strobe wrong after left feedback write");

  a_left_fb_high_lands: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    reg_wr_in && reg_addr_in == ADDR_W'(LEFT_HPF_FEEDBACK_COEF_HIGH_OFS)
    |=> left_feedback_coef_out[15:8] == $past(reg_wdata_in)
  ) else $error("left feedback high byte write did not land");

  a_left_fb_low_lands: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    reg_wr_in && reg_addr_in == ADDR_W'(LEFT_HPF_FEEDBACK_COEF_LOW_OFS)
    |=> left_feedback_coef_out[7:0] == $past(reg_wdata_in) &&
        left_feedback_coef_out[15:8] == $past(left_feedback_coef_out[15:8])
  ) else $error("left feedback low byte write did not land");

  a_num0_high_lands: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    reg_wr_in && reg_addr_in == ADDR_W'(RIGHT_HPF_NUM0_COEF_HIGH_OFS)
    |=> right_first_numerator_coef_out[15:8] == $past(reg_wdata_in)
  ) else $error("first numerator high byte write did not land");

  a_num0_low_lands: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    reg_wr_in && reg_addr_in == ADDR_W'(RIGHT_HPF_NUM0_COEF_LOW_OFS)
    |=> right_first_numerator_coef_out[7:0] == $past(reg_wdata_in)
  ) else $error("first numerator low byte write did not land");

  a_num1_high_lands: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    reg_wr_in && reg_addr_in == ADDR_W'(RIGHT_HPF_NUM1_COEF_HIGH_OFS)
    |=> right_second_numerator_coef_out[15:8] == $past(reg_wdata_in)
  ) else $error("second numerator high byte write did not land");

  a_num1_low_lands: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    reg_wr_in && reg_addr_in == ADDR_W'(RIGHT_HPF_NUM1_COEF_LOW_OFS)
    |=> right_second_numerator_coef_out[7:0] == $past(reg_wdata_in)
  ) else $error("second numerator low byte write did not land");

  a_fb_low_lands: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    reg_wr_in && reg_addr_in == ADDR_W'(RIGHT_HPF_FEEDBACK_COEF_LOW_OFS)
    |=> right_feedback_coef_out[7:0] == $past(reg_wdata_in) &&
        right_feedback_coef_out[15:8] == $past(right_feedback_coef_out[15:8])
  ) else $error("right feedback low byte write did not land");

  a_fb_update: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    reg_wr_in && reg_addr_in == ADDR_W'(RIGHT_HPF_FEEDBACK_COEF_LOW_OFS)
    |=> coef_update_out == 4'h8
  ) else $error("right feedback write gave wrong update strobe");

  a_num0_update: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    reg_wr_in && reg_addr_in == ADDR_W'(RIGHT_HPF_NUM0_COEF_LOW_OFS)
    |=> coef_update_out == 4'h2
  ) else $error("first numerator write gave wrong update strobe");

  a_num1_update: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    reg_wr_in && reg_addr_in == ADDR_W'(RIGHT_HPF_NUM1_COEF_HIGH_OFS)
    |=> coef_update_out == 4'h4
  ) else $error("second numerator write gave wrong update strobe");

  a_sign_positive: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    reg_wr_in && reg_addr_in == ADDR_W'(RIGHT_HPF_NUM0_COEF_HIGH_OFS) &&
      !reg_wdata_in[7]
    |=> right_first_numerator_coef_out >= 0
  ) else $error("positive high byte did not give a positive word");

  // ----------------------------------------------------------------
  // reserved tail checks
  // ----------------------------------------------------------------
  a_rsvd_reads_zero: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    reg_rd_in && is_rsvd_addr(reg_addr_in)
    |=> reg_rdata_out == RESERVED_READ_VAL
  ) else $error("reserved register read not zero");

  a_rsvd_write_dropped: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    wr_rsvd |=> $stable(coef_bytes) && rsvd_wr_seen_out
  ) else $error("reserved write changed the bank or was not flagged");

  a_rsvd_flag_sticky: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    rsvd_wr_seen_out |=> rsvd_wr_seen_out
  ) else $error("reserved write flag dropped without reset");

  a_rsvd_no_update: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    wr_rsvd |=> coef_update_out == 4'h0
  ) else $error("reserved write raised an update strobe");

  // ----------------------------------------------------------------
  // read-back checks
  // ----------------------------------------------------------------
  a_write_readback: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    reg_wr_in && is_coef_addr(reg_addr_in) ##1
      reg_rd_in && reg_addr_in == $past(reg_addr_in)
    |=> reg_rdata_out == $past(reg_wdata_in, 2)
  ) else $error("read-back differs from byte just written");

  a_idle_rdata_zero: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    !reg_rd_in |=> reg_rdata_out == 8'h00
  ) else $error("read data not zero outside a read answer");

  a_bank_holds: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    !wr_coef |=> $stable(coef_bytes) [*1]
  ) else $error("coefficient byte changed without a write");

  a_low_write_dropped: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    reg_wr_in && reg_addr_in < ADDR_W'(COEF_BASE_OFS)
    |=> $stable(coef_bytes) && coef_update_out == 4'h0 &&
        $stable(rsvd_wr_seen_out)
  ) else $error("write below the bank changed state");

  a_low_read_zero: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    reg_rd_in && reg_addr_in < ADDR_W'(COEF_BASE_OFS)
    |=> reg_rdata_out == 8'h00
  ) else $error("read below the bank not zero");

endmodule // adchp_coef_regs

// ---- sim/adchp_coef_regs_tb.sv ----
// Purpose: self-checking bench for the high-pass coefficient bank
// Assumes: 20 MHz clock, synchronous active-low reset, bench is bus master
// Notes:   table rows cover every coefficient byte; hand tests follow
`timescale 1ns/1ps

module testbench;
  import adchp_pkg::*;

  typedef struct {
    logic [6:0] addr;
    logic [7:0] rst_val;
    logic [7:0] new_val;
  } adchp_row_t;

  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [6:0] reg_addr_in = 7'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_rdata_out;
  logic signed [15:0] left_fb;
  logic signed [15:0] right_num0;
  logic signed [15:0] right_num1;
  logic signed [15:0] right_fb;
  logic [3:0] coef_update_out;
  logic rsvd_wr_seen_out;
  logic [7:0] exp_b [8];
  logic [6:0] hole_addr [5] = '{7'h4d, 7'h60, 7'h7f, 7'h00, 7'h44};
  int num_errors = 0;
  int tests_run = 0;
  // each byte: reset value, then a new value; left fb and right num0 words hit the signed extremes
  adchp_row_t rows [8] = '{
    '{7'h45, 8'h53, 8'h80}, '{7'h46, 8'h7e, 8'h00},
    '{7'h47, 8'h39, 8'h7f}, '{7'h48, 8'h55, 8'hff},
    '{7'h49, 8'hf3, 8'h81}, '{7'h4a, 8'h2d, 8'hfe},
    '{7'h4b, 8'h53, 8'ha5}, '{7'h4c, 8'h7e, 8'h5a}};

  always #25 ref_clk_in = ~ref_clk_in;

  adchp_coef_regs i_adchp_coef_regs (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out),
    .left_feedback_coef_out(left_fb),
    .right_first_numerator_coef_out(right_num0),
    .right_second_numerator_coef_out(right_num1),
    .right_feedback_coef_out(right_fb),
    .coef_update_out(coef_update_out),
    .rsvd_wr_seen_out(rsvd_wr_seen_out)
  );

  // ----------------------------------------------------------------
  // helper tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string what);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what,
               seen, exp);
    end
  endtask

  task automatic check_words();
    check(left_fb, {exp_b[0], exp_b[1]}, "left fb word");
    check(right_num0, {exp_b[2], exp_b[3]}, "right num0 word");
    check(right_num1, {exp_b[4], exp_b[5]}, "right num1 word");
    check(right_fb, {exp_b[6], exp_b[7]}, "right fb word");
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    check({8'h00, reg_rdata_out}, {8'h00, exp}, "read data");
  endtask

  task automatic do_reset();
    @(posedge ref_clk_in);
    rst_n_in <= 1'b0;
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    #1;
    for (int i = 0; i < 8; i++) exp_b[i] = rows[i].rst_val;
    check_words();
    check({12'h000, coef_update_out}, 16'h0000, "update in reset");
    check({15'h0, rsvd_wr_seen_out}, 16'h0000, "flag in reset");
    check({8'h00, reg_rdata_out}, 16'h0000, "rdata in reset");
    @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    // earliest legal read: strobe sampled at the first edge out of reset
    reg_rd_in <= 1'b1;
    reg_addr_in <= LEFT_HPF_FEEDBACK_COEF_LOW_OFS;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    check({8'h00, reg_rdata_out}, {8'h00, RST_LEFT_FB_LOW}, "early");
    $display("test reset done");
  endtask

  task automatic print_verdict();
    $display("tests_run %0d num_errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    do_reset();
    for (int i = 0; i < 8; i++) begin
      rd(rows[i].addr, rows[i].rst_val);
      wr(rows[i].addr, rows[i].new_val);
      exp_b[i] = rows[i].new_val;
      check({12'h000, coef_update_out}, 16'(1 << (i / 2)), "pulse");
      check_words();
      rd(rows[i].addr, rows[i].new_val);
      check({12'h000, coef_update_out}, 16'h0000, "pulse end");
    end
    check({15'h0, left_fb < 16'sh0000}, 16'h0001, "most negative");
    check({15'h0, right_num0 > 16'sh7ffe}, 16'h0001, "most pos");
    $display("test table done");

    // unmapped and reserved places read zero, writes leave the bank unchanged, reserved ones set the flag
    foreach (hole_addr[j]) rd(hole_addr[j], 8'h00);
    wr(7'h44, 8'hff);
    check({15'h0, rsvd_wr_seen_out}, 16'h0000, "flag low write");
    wr(7'h4d, 8'hff);
    check({12'h000, coef_update_out}, 16'h0000, "no pulse");
    check({15'h0, rsvd_wr_seen_out}, 16'h0001, "flag set");
    wr(7'h7f, 8'h01);
    check_words();
    rd(7'h4d, 8'h00);
    $display("test reserved done");

    // write then back-to-back reads, data stands one cycle only
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= 7'h4c;
    reg_wdata_in <= 8'h3c;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b1;
    #1;
    exp_b[7] = 8'h3c;
    check_words();
    check({12'h000, coef_update_out}, 16'h0008, "b2b pulse");
    @(posedge ref_clk_in);
    reg_addr_in <= 7'h45;
    #1;
    check({8'h00, reg_rdata_out}, 16'h003c, "b2b first");
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    check({8'h00, reg_rdata_out}, {8'h00, exp_b[0]}, "b2b next");
    @(posedge ref_clk_in);
    #1;
    check({8'h00, reg_rdata_out}, 16'h0000, "rdata idle");
    $display("test back to back done");

    // second reset in mid-run restores every byte and clears the flag
    do_reset();
    rd(7'h4c, 8'h7e);
    rd(7'h45, 8'h53);
    print_verdict();
  end

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    num_errors++;
    $display("mismatch at %0t: run did not finish", $time);
    print_verdict();
  end

endmodule // testbench
